// >>> include/dcsl_pkg.sv
/*
 * Constants for the debug control and status logic: control and status
 * bit positions, debug command codes, special control values.
 * Assumes a byte-wide command path from the serial link front end.
 */
//
// Contract
// [RULE_01] Control write 81H resets the device and leaves it halted in debug.
// [RULE_02] Control write 41H resets with breakpoints enabled, CPU then runs.
// [RULE_03] In debug mode, control write 40H clears debug, breakpoints enabled.
// [RULE_04] Debug bit 7 set stops instruction fetch; clearing it resumes.
// [RULE_05] Breakpoint opcode, enabled, loop clear: debug bit sets itself.
// [RULE_06] With read protect active, writing 0 to debug bit is ignored.
// [RULE_07] Breakpoint enable bit 6 clear (default): opcode 00H acts as no-op.
// [RULE_08] Acknowledge bit 5 set: send FFH to host on each breakpoint.
// [RULE_09] Loop bit 4 set: CPU repeats breakpoint opcode, no debug entry.
// [RULE_10] Counter-match bit 3 set: debug bit sets when PC equals counter.
// [RULE_11] Counter-match set: counter holds while CPU runs.
// [RULE_12] Zero-break bit 2 set: debug bit sets when counter reaches 0000H.
// [RULE_13] Zero-break set: counter kept, not reloaded, on leaving debug.
// [RULE_14] Host always writes 0 to reserved control bit 1.
// [RULE_15] Reset bit 0 runs power-on reset of device, debugger not reset.
// [RULE_16] Reset bit clears itself once the started reset completes.
// [RULE_17] Status bit 7: debug active or breakpoint since last control write.
// [RULE_18] Status bit 6 shows halt low-power mode.
// [RULE_19] Status bit 5 is 1 when read-protect option bit is 0.
// [RULE_20] Status bits 4..0 reserved, read as 00000.
// [RULE_21] Command 04H plus a byte writes control; 05H reads it back.
// [RULE_22] Command 02H returns one status byte.
// [RULE_23] Without counter match, counter counts down each system clock; code counts only while debug bit clear, holds at 0000H.
// [RULE_24] Control and status bits reset to 0 except halt and protect mirrors.
//
package dcsl_pkg;

    // ********************************************
    // Control and status fields
    // ********************************************
    localparam int CTL_DEBUG      = 7;
    localparam int CTL_BP_EN      = 6;
    localparam int CTL_ACK_EN     = 5;
    localparam int CTL_LOOP       = 4;
    localparam int CTL_PC_MATCH   = 3;
    localparam int CTL_ZERO_STOP  = 2;
    localparam int CTL_RSV        = 1;
    localparam int CTL_RST_REQ    = 0;
    localparam int STAT_IDLE      = 7;
    localparam int STAT_HALT      = 6;
    localparam int STAT_PROTECT   = 5;

    localparam logic [7:0]  CTL_RESET_VAL  = 8'h00;
    localparam logic [7:0]  CTL_WRITE_MASK = 8'hfd;
    localparam logic [7:0]  OPC_BREAKPOINT = 8'h00;
    localparam logic [7:0]  ACK_BYTE       = 8'hff;
    localparam logic [15:0] CNT_ZERO       = 16'h0000;
    localparam logic [15:0] CNT_ONE        = 16'h0001;

    // ********************************************
    // Command codes
    // ********************************************
    localparam logic [7:0] CMD_READ_STATUS = 8'h02;
    localparam logic [7:0] CMD_WRITE_CTL   = 8'h04;
    localparam logic [7:0] CMD_READ_CTL    = 8'h05;

    // Device reset pulse length in system clocks
    localparam logic [3:0] RST_PULSE_CYCLES = 4'h8;

endpackage

// >>> rtl/dcsl_counter.sv
/*
 * Debug counter: 16-bit down counter used for cycle counting,
 * zero-count break and program-counter match break.
 * Assumes load only arrives while in debug mode (filtered upstream).
 */
`timescale 1ns/10ps
module dcsl_counter (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Control
    input  wire logic        load_in,
    input  wire logic [15:0] load_value_in,
    input  wire logic        running_in,
    input  wire logic        pc_match_mode_in,
    input  wire logic        zero_mode_in,
    input  wire logic [15:0] pc_in,
    // Results
    output logic      [15:0] count_out,
    output logic             match_hit_out,
    output logic             zero_hit_out
);

    logic [15:0] count_q;
    logic [15:0] count_d;

    always_comb begin
        count_d = count_q;
        if (load_in) begin
            count_d = load_value_in;
        end else if (running_in && !pc_match_mode_in &&
                     count_q != dcsl_pkg::CNT_ZERO) begin
            count_d = count_q - dcsl_pkg::CNT_ONE;  // [RULE_23] [RULE_11]
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_q <= dcsl_pkg::CNT_ZERO;
        end else begin
            count_q <= count_d;  // [RULE_13]
        end
    end

    assign count_out     = count_q;
    assign match_hit_out = running_in && pc_match_mode_in &&
                           pc_in == count_q;  // [RULE_10]
    // Hit only on the decrement step, not while parked at zero
    assign zero_hit_out  = running_in && zero_mode_in && !pc_match_mode_in &&
                           count_q == dcsl_pkg::CNT_ONE;  // [RULE_12]

endmodule

// >>> rtl/dcsl_reset_seq.sv
/*
 * Device reset sequencer: issues a fixed-length reset pulse to the rest
 * of the device and reports completion. Debug logic is never reset by it.
 */
`timescale 1ns/10ps
module dcsl_reset_seq (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Request and result
    input  wire logic start_in,
    output logic      dev_reset_out,
    output logic      done_out
);

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       busy_q;
    logic       busy_d;

    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        if (start_in && !busy_q) begin
            busy_d = 1'b1;
            cnt_d  = dcsl_pkg::RST_PULSE_CYCLES;
        end else if (busy_q) begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
                busy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q  <= 4'h0;
            busy_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
        end
    end

    assign dev_reset_out = busy_q;  // [RULE_15]
    assign done_out      = busy_q && cnt_q == 4'h1;

endmodule

// >>> rtl/dcsl_top.sv
/*
 * Debug control and status logic. Decodes byte commands from the serial
 * front end, holds the control register, builds the status byte and
 * steers CPU fetch, breakpoint handling and device reset.
 * Assumes the front end delivers one command and its data byte as
 * single-cycle strobes, and takes reply bytes by a valid/ready pair.
 */
`timescale 1ns/10ps
module dcsl_top (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Command bytes from link front end
    input  wire logic        cmd_valid_in,
    input  wire logic [7:0]  cmd_code_in,
    input  wire logic        data_valid_in,
    input  wire logic [7:0]  data_in,
    // Reply bytes to link front end
    output logic             reply_valid_out,
    output logic      [7:0]  reply_data_out,
    input  wire logic        reply_ready_in,
    // Counter load from link (already decoded)
    input  wire logic        counter_load_in,
    input  wire logic [15:0] counter_value_in,
    // CPU side
    input  wire logic        opcode_decode_in,
    input  wire logic [7:0]  opcode_in,
    input  wire logic [15:0] pc_in,
    input  wire logic        halt_mode_in,
    input  wire logic        read_protect_bit_in,
    output logic             fetch_stop_out,
    output logic             break_loop_out,
    output logic             break_as_nop_out,
    output logic             device_reset_out,
    output logic      [15:0] debug_counter_out
);

    // ********************************************
    // State
    // ********************************************
    typedef enum logic [1:0] {
        DCSL_IDLE,
        DCSL_WAIT_CTL
    } dcsl_cmd_e;

    dcsl_cmd_e  cmd_q;
    dcsl_cmd_e  cmd_d;
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic       bp_seen_q;
    logic       bp_seen_d;
    logic       reply_valid_q;
    logic       reply_valid_d;
    logic [7:0] reply_q;
    logic [7:0] reply_d;
    logic       rst_start_q;
    logic       rst_start_d;

    logic        debug_mode;
    logic        protect_active;
    logic        bp_decoded;
    logic        bp_taken;
    logic        match_hit;
    logic        zero_hit;
    logic        rst_done;
    logic [7:0]  status_byte;
    logic [7:0]  wr_val;

    assign debug_mode     = ctl_q[dcsl_pkg::CTL_DEBUG];
    assign protect_active = !read_protect_bit_in;  // [RULE_19]
    assign bp_decoded     = opcode_decode_in && !debug_mode &&
                            opcode_in == dcsl_pkg::OPC_BREAKPOINT;
    assign bp_taken       = bp_decoded && ctl_q[dcsl_pkg::CTL_BP_EN];

    always_comb begin
        status_byte = 8'h00;  // [RULE_20]
        status_byte[dcsl_pkg::STAT_IDLE]    = debug_mode ||
                                              bp_seen_q;  // [RULE_17]
        status_byte[dcsl_pkg::STAT_HALT]    = halt_mode_in;  // [RULE_18]
        status_byte[dcsl_pkg::STAT_PROTECT] = protect_active;
    end

    // ********************************************
    // Command decode and control register
    // ********************************************
    always_comb begin
        cmd_d         = cmd_q;
        ctl_d         = ctl_q;
        bp_seen_d     = bp_seen_q;
        reply_valid_d = reply_valid_q;
        reply_d       = reply_q;
        rst_start_d   = 1'b0;
        wr_val        = data_in & dcsl_pkg::CTL_WRITE_MASK;  // [RULE_14]

        if (reply_valid_q && reply_ready_in) begin
            reply_valid_d = 1'b0;
        end

        case (cmd_q)
            DCSL_IDLE: begin
                if (cmd_valid_in) begin
                    if (cmd_code_in == dcsl_pkg::CMD_WRITE_CTL) begin
                        cmd_d = DCSL_WAIT_CTL;  // [RULE_21]
                    end else if (cmd_code_in == dcsl_pkg::CMD_READ_CTL) begin
                        reply_valid_d = 1'b1;
                        reply_d       = ctl_q;  // [RULE_21]
                    end else if (cmd_code_in ==
                                 dcsl_pkg::CMD_READ_STATUS) begin
                        reply_valid_d = 1'b1;
                        reply_d       = status_byte;  // [RULE_22]
                    end
                end
            end
            DCSL_WAIT_CTL: begin
                if (data_valid_in) begin
                    cmd_d      = DCSL_IDLE;
                    bp_seen_d  = 1'b0;
                    // Protect: debug bit may be set but never cleared
                    if (protect_active && debug_mode) begin
                        wr_val[dcsl_pkg::CTL_DEBUG] = 1'b1;  // [RULE_06]
                    end
                    // 81H / 41H / 40H fall out of plain bit semantics
                    ctl_d = wr_val;  // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
                    if (wr_val[dcsl_pkg::CTL_RST_REQ]) begin
                        rst_start_d = 1'b1;  // [RULE_15]
                    end
                end
            end
            default: begin
                cmd_d = DCSL_IDLE;
            end
        endcase

        // Hardware sets win over a same-cycle write
        if (bp_taken && !ctl_q[dcsl_pkg::CTL_LOOP]) begin
            ctl_d[dcsl_pkg::CTL_DEBUG] = 1'b1;  // [RULE_05]
        end
        if (match_hit || zero_hit) begin
            ctl_d[dcsl_pkg::CTL_DEBUG] = 1'b1;  // [RULE_10] [RULE_12]
        end
        if (bp_taken) begin
            bp_seen_d = 1'b1;  // [RULE_17]
        end
        // A fresh request in the finishing cycle keeps its bit set
        if (rst_done && !rst_start_d) begin
            ctl_d[dcsl_pkg::CTL_RST_REQ] = 1'b0;  // [RULE_16]
        end
        // Acknowledge byte preempts any pending reply
        if (bp_taken && ctl_q[dcsl_pkg::CTL_ACK_EN]) begin
            reply_valid_d = 1'b1;
            reply_d       = dcsl_pkg::ACK_BYTE;  // [RULE_08]
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cmd_q         <= DCSL_IDLE;
            ctl_q         <= dcsl_pkg::CTL_RESET_VAL;  // [RULE_24]
            bp_seen_q     <= 1'b0;
            reply_valid_q <= 1'b0;
            reply_q       <= 8'h00;
            rst_start_q   <= 1'b0;
        end else begin
            cmd_q         <= cmd_d;
            ctl_q         <= ctl_d;
            bp_seen_q     <= bp_seen_d;
            reply_valid_q <= reply_valid_d;
            reply_q       <= reply_d;
            rst_start_q   <= rst_start_d;
        end
    end

    // ********************************************
    // Submodules
    // ********************************************
    dcsl_counter u_counter (
        .clk_in           (clk_in),
        .rst_n_in         (rst_n_in),
        .load_in          (counter_load_in && debug_mode),
        .load_value_in    (counter_value_in),
        .running_in       (!debug_mode),
        .pc_match_mode_in (ctl_q[dcsl_pkg::CTL_PC_MATCH]),
        .zero_mode_in     (ctl_q[dcsl_pkg::CTL_ZERO_STOP]),
        .pc_in            (pc_in),
        .count_out        (debug_counter_out),
        .match_hit_out    (match_hit),
        .zero_hit_out     (zero_hit)
    );

    dcsl_reset_seq u_reset (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .start_in      (rst_start_q),
        .dev_reset_out (device_reset_out),
        .done_out      (rst_done)
    );

    // ********************************************
    // Outputs
    // ********************************************
    assign fetch_stop_out   = debug_mode;  // [RULE_04]
    assign break_loop_out   = ctl_q[dcsl_pkg::CTL_BP_EN] &&
                              ctl_q[dcsl_pkg::CTL_LOOP];  // [RULE_09]
    assign break_as_nop_out = !ctl_q[dcsl_pkg::CTL_BP_EN];  // [RULE_07]
    assign reply_valid_out  = reply_valid_q;
    assign reply_data_out   = reply_q;

endmodule

// >>> bench/dcsl_top_assertions.sv
/* Checker for dcsl_top: port-level timing of commands, debug entry,
   device reset and reset values.
   Assumes one clock domain and the hand-over latencies of the design. */
`timescale 1ns/10ps
module dcsl_top_assertions (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Command and reply
    input  wire logic        cmd_valid_in,
    input  wire logic [7:0]  cmd_code_in,
    input  wire logic        data_valid_in,
    input  wire logic [7:0]  data_in,
    input  wire logic        reply_valid_out,
    input  wire logic [7:0]  reply_data_out,
    input  wire logic        reply_ready_in,
    // CPU side
    input  wire logic        opcode_decode_in,
    input  wire logic [7:0]  opcode_in,
    input  wire logic [15:0] pc_in,
    input  wire logic        halt_mode_in,
    input  wire logic        read_protect_bit_in,
    input  wire logic        fetch_stop_out,
    input  wire logic        break_loop_out,
    input  wire logic        break_as_nop_out,
    input  wire logic        device_reset_out,
    input  wire logic [15:0] debug_counter_out
);
    // ********************************
    // Write-control tracking
    // ********************************
    logic pend_q;
    logic pend_d;
    logic wr_ok;
    logic bp_op;
    assign wr_ok  = pend_q && data_valid_in;
    assign bp_op  = opcode_decode_in && opcode_in == dcsl_pkg::OPC_BREAKPOINT;
    always_comb begin
        pend_d = pend_q;
        if (cmd_valid_in && !pend_q
            && cmd_code_in == dcsl_pkg::CMD_WRITE_CTL) begin
            pend_d = 1'b1;
        end else if (data_valid_in) begin
            pend_d = 1'b0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) pend_q <= 1'b0;
        else pend_q <= pend_d;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ********************************
    // Properties
    // ********************************
    AST_READ_REPLY: assert property (cmd_valid_in && !pend_q && !reply_valid_out
        && (cmd_code_in == dcsl_pkg::CMD_READ_STATUS
        || cmd_code_in == dcsl_pkg::CMD_READ_CTL) |=> reply_valid_out)
        else $error("read command gave no reply");
    AST_STATUS_BITS: assert property (cmd_valid_in && !pend_q
        && !reply_valid_out && !opcode_decode_in && !$past(opcode_decode_in)
        && cmd_code_in == dcsl_pkg::CMD_READ_STATUS |=> reply_data_out[6:0]
        == {$past(halt_mode_in), ~$past(read_protect_bit_in), 5'h00})
        else $error("status byte fields wrong");
    AST_DEBUG_SET: assert property (wr_ok && data_in[7] |=> fetch_stop_out)
        else $error("debug write did not stop fetch");
    AST_PROTECT_HOLD: assert property (wr_ok && fetch_stop_out
        && !read_protect_bit_in |=> fetch_stop_out)
        else $error("debug cleared under read protect");
    AST_RST_START: assert property (wr_ok && data_in[0] && !device_reset_out
        |-> ##2 $rose(device_reset_out))
        else $error("reset request did not start device reset");
    AST_RST_LEN: assert property ($rose(device_reset_out)
        |-> device_reset_out[*8] ##1 !device_reset_out)
        else $error("device reset pulse length wrong");
    AST_BP_ENTRY: assert property (bp_op && !break_as_nop_out
        && !break_loop_out && !data_valid_in |=> fetch_stop_out)
        else $error("enabled breakpoint did not enter debug");
    AST_BP_NO_ENTRY: assert property (bp_op && (break_as_nop_out
        || break_loop_out) && !fetch_stop_out && !data_valid_in
        && debug_counter_out != dcsl_pkg::CNT_ONE
        && pc_in != debug_counter_out |=> !fetch_stop_out)
        else $error("disabled or looping breakpoint entered debug");
    AST_RESET_VALS: assert property (disable iff (1'b0) !rst_n_in |=>
        !fetch_stop_out && break_as_nop_out && !break_loop_out
        && !device_reset_out && debug_counter_out == dcsl_pkg::CNT_ZERO)
        else $error("outputs not at reset values");
    COV_RESET_STOP: cover property (wr_ok && data_in == 8'h81);
    COV_LOOP: cover property (bp_op && break_loop_out);
    COV_ACK: cover property (reply_valid_out && reply_ready_in
        && reply_data_out == dcsl_pkg::ACK_BYTE);
endmodule
bind dcsl_top dcsl_top_assertions u_chk (.clk_in, .rst_n_in, .cmd_valid_in,
    .cmd_code_in, .data_valid_in, .data_in, .reply_valid_out, .reply_data_out,
    .reply_ready_in, .opcode_decode_in, .opcode_in, .pc_in, .halt_mode_in,
    .read_protect_bit_in, .fetch_stop_out, .break_loop_out, .break_as_nop_out,
    .device_reset_out, .debug_counter_out);

// >>> bench/dcsl_host_model.sv
/* Debug host model: sends command and data bytes as one-cycle strobes and
   takes reply bytes by valid/ready, with an optional stall.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/10ps
module dcsl_host_model (
    // Clock
    input  wire logic       clk_in,
    // Command side
    output logic            cmd_valid_out,
    output logic      [7:0] cmd_code_out,
    output logic            data_valid_out,
    output logic      [7:0] data_out,
    // Reply side
    input  wire logic       reply_valid_in,
    input  wire logic [7:0] reply_data_in,
    output logic            reply_ready_out
);
    int stall = 0;
    initial begin
        cmd_valid_out   = 1'b0;
        cmd_code_out    = 8'h00;
        data_valid_out  = 1'b0;
        data_out        = 8'h00;
        reply_ready_out = 1'b0;
    end
    task automatic put(input logic [7:0] b, input logic is_data);
        @(negedge clk_in);
        if (is_data) begin
            data_out       <= b & 8'hfd;
            data_valid_out <= 1'b1;
        end else begin
            cmd_code_out  <= b;
            cmd_valid_out <= 1'b1;
        end
        @(negedge clk_in);
        cmd_valid_out  <= 1'b0;
        data_valid_out <= 1'b0;
        // Released bytes flip so a stale value never looks valid
        cmd_code_out   <= ~cmd_code_out;
        data_out       <= ~data_out;
    endtask
    task automatic take(output logic [7:0] b, output bit ok);
        int n;
        ok = 1'b0;
        b  = 8'h00;
        // Valid looked at mid-cycle, away from its launching edge
        for (n = 0; n < 50 && !ok; n++) begin
            @(negedge clk_in);
            ok = (reply_valid_in === 1'b1);
        end
        if (ok) begin
            repeat (stall) @(negedge clk_in);
            b = reply_data_in;
            reply_ready_out <= 1'b1;
            @(negedge clk_in);
            reply_ready_out <= 1'b0;
        end
    endtask
endmodule

// >>> bench/dcsl_top_tb.sv
/* Bench for dcsl_top: host model issues commands, bench drives CPU side.
   Assumes package, design and checker files are compiled first. */
`timescale 1ns/10ps
module dcsl_top_tb;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        cmd_valid_in, data_valid_in, reply_ready_in, reply_valid_out;
    logic [7:0]  cmd_code_in, data_in, reply_data_out;
    logic        counter_load_in = 1'b0, opcode_decode_in = 1'b0;
    logic        halt_mode_in = 1'b0, read_protect_bit_in = 1'b1;
    logic [15:0] counter_value_in = 16'h0000, pc_in = 16'h0200;
    logic [7:0]  opcode_in = 8'h00;
    logic        fetch_stop_out, break_loop_out, break_as_nop_out;
    logic        device_reset_out;
    logic [15:0] debug_counter_out;
    int          num_errors = 0;
    int          tests_run = 0;
    always #5 clk_in = ~clk_in;
    dcsl_top u_dut (.clk_in, .rst_n_in, .cmd_valid_in, .cmd_code_in,
        .data_valid_in, .data_in, .reply_valid_out, .reply_data_out,
        .reply_ready_in, .counter_load_in, .counter_value_in,
        .opcode_decode_in, .opcode_in, .pc_in, .halt_mode_in,
        .read_protect_bit_in, .fetch_stop_out, .break_loop_out,
        .break_as_nop_out, .device_reset_out, .debug_counter_out);
    dcsl_host_model u_host (.clk_in, .cmd_valid_out(cmd_valid_in),
        .cmd_code_out(cmd_code_in), .data_valid_out(data_valid_in),
        .data_out(data_in), .reply_valid_in(reply_valid_out),
        .reply_data_in(reply_data_out), .reply_ready_out(reply_ready_in));
    // ********************************
    // Tasks
    // ********************************
    task automatic stop_test();
        $display("Checks run %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic get(input string name, input logic [7:0] exp);
        logic [7:0] b;
        bit ok;
        u_host.take(b, ok);
        if (!ok) begin
            num_errors++;
            $display("BAD %s expected reply seen timeout", name);
            stop_test();
        end else chk(name, {8'h00, exp}, {8'h00, b});
    endtask
    task automatic wr(input logic [7:0] v);
        u_host.put(dcsl_pkg::CMD_WRITE_CTL, 1'b0);
        u_host.put(v, 1'b1);
    endtask
    task automatic rd_ctl(input logic [7:0] exp);
        u_host.put(dcsl_pkg::CMD_READ_CTL, 1'b0);
        get("control", exp);
    endtask
    task automatic rd_stat(input logic [7:0] exp);
        u_host.put(dcsl_pkg::CMD_READ_STATUS, 1'b0);
        get("status", exp);
    endtask
    task automatic hit_bp();
        @(negedge clk_in);
        opcode_decode_in = 1'b1;
        @(negedge clk_in);
        opcode_decode_in = 1'b0;
    endtask
    task automatic ld(input logic [15:0] v);
        @(negedge clk_in);
        counter_load_in  = 1'b1;
        counter_value_in = v;
        @(negedge clk_in);
        counter_load_in  = 1'b0;
        counter_value_in = ~v;
    endtask
    // ********************************
    // Sequence
    // ********************************
    initial begin
        repeat (16) @(negedge clk_in);
        rst_n_in = 1'b1;
        rd_ctl(8'h00);
        rd_stat(8'h00);
        chk("nop", 16'h1, {15'h0, break_as_nop_out});
        wr(8'h81);
        repeat (2) @(negedge clk_in);
        chk("dev_rst", 16'h1, {15'h0, device_reset_out});
        repeat (12) @(negedge clk_in);
        chk("fetch", 16'h1, {15'h0, fetch_stop_out});
        rd_ctl(8'h80);
        chk("dev_rst", 16'h0, {15'h0, device_reset_out});
        wr(8'h40);
        chk("fetch", 16'h0, {15'h0, fetch_stop_out});
        wr(8'h60);
        hit_bp();
        u_host.stall = 2;
        get("ack", dcsl_pkg::ACK_BYTE);
        chk("fetch", 16'h1, {15'h0, fetch_stop_out});
        rd_stat(8'h80);
        wr(8'h41);
        repeat (14) @(negedge clk_in);
        rd_ctl(8'h40);
        chk("fetch", 16'h0, {15'h0, fetch_stop_out});
        wr(8'h50);
        hit_bp();
        chk("loop", 16'h1, {15'h0, break_loop_out});
        chk("fetch", 16'h0, {15'h0, fetch_stop_out});
        rd_stat(8'h80);
        wr(8'h00);
        rd_stat(8'h00);
        hit_bp();
        chk("fetch", 16'h0, {15'h0, fetch_stop_out});
        wr(8'h80);
        ld(16'h0020);
        wr(8'h04);
        chk("count", 16'h0020, debug_counter_out);
        repeat (3) @(negedge clk_in);
        chk("count", 16'h001d, debug_counter_out);
        repeat (40) @(negedge clk_in);
        chk("count", 16'h0000, debug_counter_out);
        chk("fetch", 16'h1, {15'h0, fetch_stop_out});
        ld(16'h0100);
        wr(8'h0c);
        repeat (5) @(negedge clk_in);
        chk("count", 16'h0100, debug_counter_out);
        pc_in = 16'h0100;
        repeat (3) @(negedge clk_in);
        chk("fetch", 16'h1, {15'h0, fetch_stop_out});
        read_protect_bit_in = 1'b0;
        halt_mode_in = 1'b1;
        wr(8'h00);
        chk("fetch", 16'h1, {15'h0, fetch_stop_out});
        rd_stat(8'he0);
        stop_test();
    end
endmodule
